/* File: rtl/oed_pkg.sv */
package oed_pkg;

  // Byte addresses of the APB register map
  localparam logic [7:0] OED_OFS_VOL_DESC = 8'h00;
  localparam logic [7:0] OED_OFS_NV_DESC = 8'h04;
  localparam logic [7:0] OED_OFS_CTRL = 8'h08;
  localparam logic [7:0] OED_OFS_STATUS = 8'h0c;

  // Field positions shared by both descriptor words
  localparam int OED_POS_AVAIL = 31;
  localparam int OED_POS_POL = 30;
  localparam int OED_POS_OTP = 29;
  localparam int OED_POS_ADDRD = 28;
  localparam int OED_POS_BYTE1 = 27;
  localparam int OED_POS_BITLOC = 24;
  localparam int OED_POS_MODE8D = 23;
  localparam int OED_POS_MODE8S = 22;
  localparam int OED_POS_MODE4D = 21;
  localparam int OED_POS_MODE4S = 20;
  localparam int OED_POS_DUMMY = 16;
  localparam int OED_POS_RDOP = 8;
  localparam int OED_POS_WROP = 0;

  // Reset values
  localparam logic [31:0] OED_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] OED_UNMAPPED_DATA = 32'h0000_0000;

  // Control word fields
  localparam int OED_CTRL_LOCK = 0;
  localparam int OED_CTRL_HIDE_VOL = 1;
  localparam int OED_CTRL_HIDE_NV = 2;

  // Descriptor field decode results
  typedef struct packed {
    logic avail;
    logic pol;
    logic otp;
    logic addrd;
    logic byte1;
    logic [2:0] bitloc;
    logic [7:0] locaddr;
    logic [3:0] modes;
    logic [3:0] dummy;
    logic [7:0] rdop;
    logic [7:0] wrop;
  } oed_fields_t;

endpackage

/* File: rtl/oed_top.sv */
`timescale 1ns/100ps
`default_nettype none

// How it works
// RULE1 - Volatile word bit 31 reads 1 only when a volatile enable bit exists.
// RULE2 - Volatile bit 30 is polarity: 0 means enable bit 1 turns octal on.
// RULE3 - Volatile bit 29 is reserved and always reads 0.
// RULE4 - Bit 28 picks direct commands (0) or addressed commands (1).
// RULE5 - Bit 27 at 0 puts the local address in the lowest address byte.
// RULE6 - Bit 27 at 1 uses address byte 1; not allowed with 8-bit addressing.
// RULE7 - Bits 26 to 24 give the enable bit position, 0 to 7.
// RULE8 - With bit 28 set, bits 23 to 16 hold the register local address.
// RULE9 - Direct mode: bit 23 flags 8D-8D-8D support with the dummy count.
// RULE10 - Direct mode: bit 22 flags 8S-8S-8S support with the dummy count.
// RULE11 - Direct mode: bit 21 flags 4S-4D-4D support with the dummy count.
// RULE12 - Direct mode: bit 20 flags 4S-4S-4S support with the dummy count.
// RULE13 - Direct mode: bits 19 to 16 hold dummy cycles, 0 to 15.
// RULE14 - Single-line mode always runs the direct command with zero dummy cycles.
// RULE15 - Unflagged or unlisted modes may still work; host must not assume absence.
// RULE16 - Bits 15 to 8 are the read opcode; zero means no read allowed.
// RULE17 - Bits 7 to 0 are the write opcode; zero means no write allowed.
// RULE18 - Non-volatile word bit 31 reads 1 only when that enable bit exists.
// RULE19 - Non-volatile bit 30 is polarity, same sense as volatile.
// RULE20 - Non-volatile bit 29 marks the enable bit one-time programmable.
// RULE21 - Non-volatile bit 27 chooses address byte 1 or byte 0.
// RULE22 - Non-volatile bits 26..16 mirror position and address or mode fields.
// RULE23 - Non-volatile opcodes sit in bits 15..8 and 7..0, zero unsupported.
// RULE24 - Host enables octal only if available and write opcode nonzero.
// RULE25 - Host never rewrites an already programmed one-time enable bit.
module oed_top
  import oed_pkg::*;
#(
  // Volatile enable bit description
  parameter bit VOL_AVAIL = 1'b1,
  parameter bit VOL_POL = 1'b0,
  parameter bit VOL_ADDRD = 1'b0,
  parameter bit VOL_BYTE1 = 1'b0,
  parameter int VOL_BITLOC = 3,
  parameter logic [7:0] VOL_LOCADDR = 8'h00,
  parameter logic [3:0] VOL_MODES = 4'hf,
  parameter int VOL_DUMMY = 8,
  parameter logic [7:0] VOL_RDOP = 8'h65,
  parameter logic [7:0] VOL_WROP = 8'h61,
  // Non-volatile enable bit description
  parameter bit NV_AVAIL = 1'b1,
  parameter bit NV_POL = 1'b0,
  parameter bit NV_OTP = 1'b0,
  parameter bit NV_ADDRD = 1'b1,
  parameter bit NV_BYTE1 = 1'b0,
  parameter int NV_BITLOC = 5,
  parameter logic [7:0] NV_LOCADDR = 8'h02,
  parameter logic [3:0] NV_MODES = 4'h0,
  parameter int NV_DUMMY = 0,
  parameter logic [7:0] NV_RDOP = 8'hb5,
  parameter logic [7:0] NV_WROP = 8'hb1,
  // Address width the device uses: 8, 24 or 32
  parameter int ADDR_BITS = 24
)(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Decoded host view of the volatile descriptor
  output logic VOL_USABLE_O,
  output logic VOL_ON_LEVEL_O,
  output logic [31:0] VOL_ADDR_MASK_O,
  // Decoded host view of the non-volatile descriptor
  output logic NV_USABLE_O,
  output logic NV_ON_LEVEL_O,
  output logic NV_WRITE_ONCE_O
);

  // Elaboration checks; a field that overflows would corrupt its neighbour
  if (VOL_BITLOC < 0 || VOL_BITLOC > 7)
  begin
    $error("volatile bit position out of range");
  end
  if (NV_BITLOC < 0 || NV_BITLOC > 7)
  begin
    $error("non-volatile bit position out of range");
  end
  if (VOL_DUMMY < 0 || VOL_DUMMY > 15)
  begin
    $error("volatile dummy count out of range");
  end
  if (NV_DUMMY < 0 || NV_DUMMY > 15)
  begin
    $error("non-volatile dummy count out of range");
  end
  // Only three address widths exist on the serial link
  if (ADDR_BITS != 8 && ADDR_BITS != 24 && ADDR_BITS != 32)
  begin
    $error("address width must be 8, 24 or 32");
  end
  // Byte 1 does not exist in an 8-bit address
  if (ADDR_BITS == 8 && VOL_BYTE1) // RULE6
  begin
    $error("volatile byte 1 placement needs 24 or 32 bit addressing");
  end
  if (ADDR_BITS == 8 && NV_BYTE1) // RULE6 RULE21
  begin
    $error("non-volatile byte 1 placement needs 24 or 32 bit addressing");
  end

  // Packs one descriptor word; field 23..16 depends on access style
  function automatic logic [31:0] pack_desc(input oed_fields_t f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[OED_POS_AVAIL] = f.avail; // RULE1 RULE18
    w[OED_POS_POL] = f.pol; // RULE2 RULE19
    w[OED_POS_OTP] = f.otp; // RULE3 RULE20
    w[OED_POS_ADDRD] = f.addrd; // RULE4
    w[OED_POS_BYTE1] = f.byte1; // RULE5 RULE6 RULE21
    w[OED_POS_BITLOC +: 3] = f.bitloc; // RULE7 RULE22
    if (f.addrd)
      w[OED_POS_DUMMY +: 8] = f.locaddr; // RULE8
    else
    begin
      // Only the four wide modes are flagged; single-line runs with no dummies,
      // and a cleared flag does not mean the mode is absent
      w[OED_POS_MODE8D] = f.modes[3]; // RULE9
      w[OED_POS_MODE8S] = f.modes[2]; // RULE10
      w[OED_POS_MODE4D] = f.modes[1]; // RULE11
      w[OED_POS_MODE4S] = f.modes[0]; // RULE12
      w[OED_POS_DUMMY +: 4] = f.dummy; // RULE13 RULE14 RULE15
    end
    w[OED_POS_RDOP +: 8] = f.rdop; // RULE16 RULE23
    w[OED_POS_WROP +: 8] = f.wrop; // RULE17 RULE23
    return w;
  endfunction

  // Usable for enabling only with a real write command
  function automatic logic usable(input logic [31:0] w);
    return w[OED_POS_AVAIL] && (w[OED_POS_WROP +: 8] != 8'h00);
  endfunction

  // Where the local address byte lands in the sent address
  function automatic logic [31:0] addr_mask(input logic [31:0] w);
    if (!w[OED_POS_ADDRD])
      return 32'h0000_0000;
    else if (w[OED_POS_BYTE1])
      return 32'h0000_ff00;
    else
      return 32'h0000_00ff;
  endfunction

  // Descriptor words are the only ones whose reads are counted
  function automatic logic is_desc(input logic [7:0] a);
    return (a == OED_OFS_VOL_DESC) || (a == OED_OFS_NV_DESC);
  endfunction

  // Descriptor images as fields and as packed words
  oed_fields_t vol_f;
  oed_fields_t nv_f;
  logic [31:0] vol_word;
  logic [31:0] nv_word;
  // Control state and bus side decode
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] prdata_d;
  logic [1:0] rd_count_q;
  logic err_d;
  logic setup;
  logic access;

  // Fixed descriptor contents; the reserved volatile bit is forced low
  always_comb
  begin
    vol_f = '0;
    vol_f.avail = VOL_AVAIL;
    vol_f.pol = VOL_POL;
    vol_f.otp = 1'b0; // RULE3
    vol_f.addrd = VOL_ADDRD;
    vol_f.byte1 = VOL_BYTE1;
    vol_f.bitloc = VOL_BITLOC[2:0];
    vol_f.locaddr = VOL_LOCADDR;
    vol_f.modes = VOL_MODES;
    vol_f.dummy = VOL_DUMMY[3:0];
    vol_f.rdop = VOL_RDOP;
    vol_f.wrop = VOL_WROP;
  end

  // Fixed non-volatile contents; here bit 29 is the write-once flag
  always_comb
  begin
    nv_f = '0;
    nv_f.avail = NV_AVAIL;
    nv_f.pol = NV_POL;
    nv_f.otp = NV_OTP; // RULE20
    nv_f.addrd = NV_ADDRD;
    nv_f.byte1 = NV_BYTE1;
    nv_f.bitloc = NV_BITLOC[2:0];
    nv_f.locaddr = NV_LOCADDR;
    nv_f.modes = NV_MODES;
    nv_f.dummy = NV_DUMMY[3:0];
    nv_f.rdop = NV_RDOP;
    nv_f.wrop = NV_WROP;
  end

  // Software may hide a descriptor, which then reads as zero and unavailable
  always_comb
  begin
    vol_word = pack_desc(vol_f);
    if (ctrl_q[OED_CTRL_HIDE_VOL])
      vol_word = 32'h0000_0000; // RULE1
  end

  // Same for the non-volatile word; hiding also drops its write-once flag
  always_comb
  begin
    nv_word = pack_desc(nv_f);
    if (ctrl_q[OED_CTRL_HIDE_NV])
      nv_word = 32'h0000_0000; // RULE18
  end

  // Bus phases; setup carries the request, access completes it
  assign setup = PSEL_I && !PENABLE_I;
  assign access = PSEL_I && PENABLE_I;

  // Zero wait states: every access completes in its first access cycle
  // The answer is already latched at setup, so no wait is ever needed
  assign PREADY_O = 1'b1;

  // Read mux and error decode; descriptors refuse writes
  always_comb
  begin
    prdata_d = OED_UNMAPPED_DATA;
    err_d = 1'b0;
    ctrl_d = ctrl_q;
    case (PADDR_I)
      OED_OFS_VOL_DESC:
      begin
        // Descriptors are fixed; any write is refused
        prdata_d = vol_word;
        err_d = PWRITE_I;
      end
      OED_OFS_NV_DESC:
      begin
        // Same refusal for the non-volatile word
        prdata_d = nv_word;
        err_d = PWRITE_I;
      end
      OED_OFS_CTRL:
      begin
        prdata_d = ctrl_q;
        // Locked control ignores further writes and reports an error
        err_d = PWRITE_I && ctrl_q[OED_CTRL_LOCK];
        if (PWRITE_I && !ctrl_q[OED_CTRL_LOCK] && PSTRB_I[0])
          ctrl_d = {29'h0, PWDATA_I[2:0]};
      end
      OED_OFS_STATUS:
      begin
        // Status is computed, so writes are refused too
        prdata_d = {28'h000_0000, rd_count_q, usable(nv_word), usable(vol_word)};
        err_d = PWRITE_I;
      end
      default:
        // Holes in the map answer zero with an error
        err_d = 1'b1;
    endcase
  end

  // Control register; write lands only at the access edge
  // Lock holds until reset, so stray software cannot undo a setting
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      ctrl_q <= OED_CTRL_RST;
    else if (access && PWRITE_I)
      ctrl_q <= ctrl_d;
  end

  // Read data latched at setup and held through access; writes return zero
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      PRDATA_O <= 32'h0000_0000;
    else if (setup)
      PRDATA_O <= PWRITE_I ? 32'h0000_0000 : prdata_d;
  end

  // Error latched at setup, dropped once the master releases the bus
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      PSLVERR_O <= 1'b0;
    else if (setup)
      PSLVERR_O <= err_d;
    else if (!PSEL_I)
      PSLVERR_O <= 1'b0;
  end

  // Saturating count of descriptor reads; it sticks rather than wrap to a small value
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      rd_count_q <= 2'h0;
    else if (access && !PWRITE_I && rd_count_q != 2'h3 && is_desc(PADDR_I))
      rd_count_q <= rd_count_q + 2'h1;
  end

  // Volatile decoded view; level that turns octal on is inverse of polarity
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      VOL_USABLE_O <= 1'b0;
      VOL_ON_LEVEL_O <= 1'b1;
      VOL_ADDR_MASK_O <= 32'h0000_0000;
    end
    else
    begin
      VOL_USABLE_O <= usable(vol_word); // RULE24 RULE17
      VOL_ON_LEVEL_O <= !vol_word[OED_POS_POL]; // RULE2
      VOL_ADDR_MASK_O <= addr_mask(vol_word); // RULE5 RULE6
    end
  end

  // Non-volatile decoded view; write-once warns the host off a second program
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      NV_USABLE_O <= 1'b0;
      NV_ON_LEVEL_O <= 1'b1;
      NV_WRITE_ONCE_O <= 1'b0;
    end
    else
    begin
      NV_USABLE_O <= usable(nv_word); // RULE24
      NV_ON_LEVEL_O <= !nv_word[OED_POS_POL]; // RULE19
      NV_WRITE_ONCE_O <= nv_word[OED_POS_OTP]; // RULE25 RULE20
    end
  end

endmodule

`default_nettype wire

/* File: bench/oed_chk_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module oed_chk
  import oed_pkg::*;
(
  // Clock, reset and bus
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PSLVERR_O,
  // Decoded views
  input wire logic VOL_USABLE_O,
  input wire logic VOL_ON_LEVEL_O,
  input wire logic [31:0] VOL_ADDR_MASK_O,
  input wire logic NV_ON_LEVEL_O,
  input wire logic NV_USABLE_O,
  input wire logic NV_WRITE_ONCE_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  logic rd_s;
  logic wr_s;
  // Setup cycles, read data lands one edge later
  assign rd_s = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign wr_s = PSEL_I && !PENABLE_I && PWRITE_I;
  ro_write_a: assert property (wr_s && PADDR_I inside {8'h00, 8'h04, 8'h0c} |=> PSLVERR_O)
    else $error("write to read-only word not refused");
  unmapped_a: assert property (rd_s && PADDR_I > 8'h0c |=> PSLVERR_O && PRDATA_O == 32'h0)
    else $error("unmapped read not refused");
  rsvd_zero_a: assert property (rd_s && PADDR_I == 8'h00 |=> !PRDATA_O[29])
    else $error("reserved bit set");
  vol_use_a: assert property (rd_s && PADDR_I == 8'h00 |=>
    VOL_USABLE_O == (PRDATA_O[31] && PRDATA_O[7:0] != 8'h00)) else $error("vol usable wrong");
  nv_use_a: assert property (rd_s && PADDR_I == 8'h04 |=>
    NV_USABLE_O == (PRDATA_O[31] && PRDATA_O[7:0] != 8'h00)) else $error("nv usable wrong");
  vol_pol_a: assert property (rd_s && PADDR_I == 8'h00 |=>
    !PRDATA_O[31] || VOL_ON_LEVEL_O == !PRDATA_O[30]) else $error("vol on level wrong");
  nv_view_a: assert property (rd_s && PADDR_I == 8'h04 |=> !PRDATA_O[31] ||
    (NV_ON_LEVEL_O == !PRDATA_O[30] && NV_WRITE_ONCE_O == PRDATA_O[29]))
    else $error("nv view wrong");
  vol_mask_a: assert property (rd_s && PADDR_I == 8'h00 ##1 PRDATA_O[31] |->
    VOL_ADDR_MASK_O == (!PRDATA_O[28] ? 32'h0 : PRDATA_O[27] ? 32'h0000ff00 : 32'h000000ff))
    else $error("vol mask wrong");
endmodule
bind oed_top oed_chk oed_chk_i (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
  .PSLVERR_O(PSLVERR_O), .VOL_USABLE_O(VOL_USABLE_O), .VOL_ON_LEVEL_O(VOL_ON_LEVEL_O),
  .VOL_ADDR_MASK_O(VOL_ADDR_MASK_O), .NV_ON_LEVEL_O(NV_ON_LEVEL_O),
  .NV_USABLE_O(NV_USABLE_O), .NV_WRITE_ONCE_O(NV_WRITE_ONCE_O));
`default_nettype wire

/* File: bench/oed_host.sv */
`timescale 1ns/100ps
`default_nettype none
module oed_host
(
  // Clock and slave answer
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic [31:0] prdata_i,
  input wire logic pslverr_i,
  // Request
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic [3:0] pstrb_o
);
  initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, pstrb_o} = '0;
  // Usable only with the bit present and a write opcode
  function automatic logic usable(input logic [31:0] w);
    return w[31] && w[7:0] != 8'h00;
  endfunction
  // Where the local address byte goes in the sent address
  function automatic logic [31:0] mask(input logic [31:0] w);
    return !w[28] ? 32'h0 : w[27] ? 32'h0000ff00 : 32'h000000ff;
  endfunction
  // Request held until pready is seen; the bench watchdog ends a dead wait
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] rd, output logic er);
    begin
      @(posedge clk_i);
      {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, pstrb_o} <= {2'b10, w, a, d, s};
      @(posedge clk_i);
      penable_o <= 1'b1;
      do
      begin
        @(posedge clk_i);
      end
      while (!pready_i);
      rd = prdata_i;
      er = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, rst, psel, pen, pwr, prdy, perr, vu, vo, nu, nvo, nwo, er;
  logic [7:0] pa;
  logic [31:0] pwd, prd, vm, rd;
  logic [3:0] pst;
  logic [2:0] ctl;
  logic [1:0] cnt;
  int errors, compares;
  // Default descriptor contents, built field by field
  localparam logic [31:0] VW = {5'b10000, 3'd3, 4'hf, 4'h8, 8'h65, 8'h61};
  localparam logic [31:0] NW = {5'b10010, 3'd5, 8'h02, 8'hb5, 8'hb1};
  oed_top oed_top_i (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PSTRB_I(pst), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(perr), .VOL_USABLE_O(vu), .VOL_ON_LEVEL_O(vo),
    .VOL_ADDR_MASK_O(vm), .NV_USABLE_O(nu), .NV_ON_LEVEL_O(nvo), .NV_WRITE_ONCE_O(nwo));
  oed_host oed_host_i (.clk_i(clk), .pready_i(prdy), .prdata_i(prd), .pslverr_i(perr),
    .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(pa), .pwdata_o(pwd), .pstrb_o(pst));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task print_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Expected read data from the mirrored control and read count
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00: return ctl[1] ? 32'h0 : VW;
      8'h04: return ctl[2] ? 32'h0 : NW;
      8'h08: return {29'h0, ctl};
      8'h0c: return {28'h0, cnt, !ctl[2], !ctl[1]};
      default: return 32'h0;
    endcase
  endfunction
  // Decoded views against the host reading of the words
  task dec;
    chk("vu", {31'h0, vu}, {31'h0, oed_host_i.usable(exp_rd(8'h00))});
    chk("nu", {31'h0, nu}, {31'h0, oed_host_i.usable(exp_rd(8'h04))});
    chk("lvl", {30'h0, vo, nvo}, {30'h0, !VW[30], !NW[30]});
    chk("once", {31'h0, nwo}, {31'h0, NW[29]});
    chk("mask", vm, oed_host_i.mask(VW));
  endtask
  // One access with its expected error and data
  task op(input logic w, input logic [7:0] a, input logic [2:0] d, input logic sb);
    logic ee;
    oed_host_i.xfer(w, a, {29'h0, d}, {3'b111, sb}, rd, er);
    ee = a > 8'h0c || (w && (a != 8'h08 || ctl[0]));
    chk("err", {31'h0, er}, {31'h0, ee});
    if (!w)
      chk("rdata", rd, exp_rd(a));
    if (w && !ee && sb)
      ctl = d;
    if (!w && a < 8'h08 && cnt != 2'd3)
      cnt++;
    // Decoded views follow a control write one edge later
    repeat (2) @(posedge clk);
    dec();
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    print_verdict();
  end
  initial
  begin
    rst = 1'b1;
    ctl = 3'h0;
    cnt = 2'h0;
    void'($urandom(11));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    dec();
    op(0, 8'h00, 0, 1);
    op(0, 8'h04, 0, 1);
    op(1, 8'h00, 7, 1);
    op(0, 8'h0c, 0, 1);
    op(0, 8'h14, 0, 1);
    op(1, 8'h08, 6, 0);
    op(1, 8'h08, 6, 1);
    op(0, 8'h00, 0, 1);
    op(1, 8'h08, 1, 1);
    op(1, 8'h08, 0, 1);
    // Mid-run reset clears the lock and count
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("rst view", {25'h0, vu, vo, nu, nvo, nwo, perr, prdy}, {25'h0, 7'b0101001});
    chk("rst data", prd, 32'h0);
    chk("rst mask", vm, 32'h0);
    rst <= 1'b0;
    ctl = 3'h0;
    cnt = 2'h0;
    op(0, 8'h08, 0, 1);
    repeat (40)
      op(1'($urandom_range(0, 1)), 8'($urandom_range(0, 7) * 4), 3'($urandom), 1'($urandom));
    print_verdict();
  end
endmodule
`default_nettype wire
